// >>> hw/sbc_pkg.sv
package sbc_pkg;
    localparam int CMD_W = 5;
    localparam int AD_W = 32;
    localparam int DW_W = 64;
    // Command and data identifier bit positions.
    localparam int B_DATA = 4;
    localparam int B_RW = 3;
    localparam int B_BLK = 2;
    localparam int B_LAST = 3;
    localparam int B_RESP = 2;
    localparam int B_ERR = 1;
    localparam int B_CHK = 0;
    localparam logic [1:0] BSZ_2 = 2'h0;
    localparam logic [1:0] BSZ_4 = 2'h1;
    localparam logic [1:0] BSZ_8 = 2'h2;
    localparam logic [1:0] BSZ_RSV = 2'h3;
    localparam logic [1:0] RSZ_WORD = 2'h3;
    localparam logic [4:0] ALIGN8_MASK = 5'h1F;
    localparam logic [31:0] SUB_TOGGLE = 32'h0000_0010;
    localparam int DW_LSB = 3;
    // Release latency figures in processor cycles.
    localparam int REL_MIN_CYC = 4;
    localparam int REL_CAT1_MAX = 6;
    localparam int REL_CAT2_MAX = 24;
    localparam int REGAIN_CYC = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = 35;

    function automatic logic [CMD_W-1:0] rd_cmd(input logic blk, input logic [1:0] sz);
        rd_cmd = {1'b0, 1'b0, blk, sz};
    endfunction : rd_cmd

    function automatic logic [3:0] words_of(input logic [CMD_W-1:0] c);
        if (!c[B_BLK]) begin
            words_of = 4'h1;
        end else begin
            unique case (c[1:0])
                BSZ_2: words_of = 4'h2;
                BSZ_4: words_of = 4'h4;
                default: words_of = 4'h8;
            endcase
        end
    endfunction : words_of

    // Data identifier sent by the agent: response data, reserved check bit at one.
    function automatic logic [CMD_W-1:0] agt_data_id(input logic last, input logic err);
        agt_data_id = {1'b1, ~last, 1'b0, err, 1'b1};
    endfunction : agt_data_id
endpackage : sbc_pkg

// >>> hw/sbc_if.sv
`timescale 1ns/1ns
interface sbc_if;
    logic [4:0] dev_cmd;
    logic dev_cmd_oe_n;
    logic [31:0] dev_ad;
    logic dev_ad_oe_n;
    logic proc_addr_valid_n;
    logic proc_bus_owner_n;
    logic [4:0] agt_cmd;
    logic agt_cmd_oe_n;
    logic [31:0] agt_ad;
    logic agt_ad_oe_n;
    logic agent_data_valid_n;
    logic ext_bus_request_n;
    logic [4:0] sys_command_bus;
    logic [31:0] sys_addr_data_bus;

    // Idle lines float high through pull-ups.
    assign sys_command_bus = !dev_cmd_oe_n ? dev_cmd : (!agt_cmd_oe_n ? agt_cmd : 5'h1F);
    assign sys_addr_data_bus = !dev_ad_oe_n ? dev_ad : (!agt_ad_oe_n ? agt_ad : 32'hFFFF_FFFF);

    modport dev (
        output dev_cmd, dev_cmd_oe_n, dev_ad, dev_ad_oe_n, proc_addr_valid_n, proc_bus_owner_n,
        input sys_command_bus, sys_addr_data_bus, agent_data_valid_n, ext_bus_request_n
    );
    modport agt (
        output agt_cmd, agt_cmd_oe_n, agt_ad, agt_ad_oe_n, agent_data_valid_n, ext_bus_request_n,
        input sys_command_bus, sys_addr_data_bus, proc_addr_valid_n, proc_bus_owner_n
    );
endinterface : sbc_if

// >>> hw/sbc_proc.sv
// Behaviour
// - Latency counts request assertion to owner release.
// - Request before final cycle: release in 4-6; the code releases only once the read has ended.
// - Otherwise release within 4 to 24 cycles.
// - Agent drives reserved bits to one.
// - Agent ignores reserved bits from processor.
// - Commands and identifiers are five-bit codes.
// - Top bit: zero command, one data.
// - Bit three: zero read, one write.
// - Bit two: single or block read.
// - Block size: two, four, eight words.
// - Eight words only when aligned, else split.
// - Single read size: byte to word.
// - Doubleword word order follows endianness.
// - Single word uses same lanes always.
// - Endian pin selects word ordering.
// - Identifier bit three zero on last element.
// - Agent flags response data and errors.
`timescale 1ns/1ns
module sbc_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
    logic push, pop;

    assign in_ready = (wr_ff - rd_ff) != (AW+1)'(D);
    assign out_valid = wr_ff != rd_ff;
    assign out_data = mem[rd_ff[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
        end
    end

    // Storage carries no reset so it maps onto plain register arrays.
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ff[AW-1:0]] <= in_data;
        end
    end
endmodule : sbc_fifo

////////////////////////////////////////////////////////////////////////////////
module sbc_proc (
    input wire logic mclk,
    input wire logic sys_rst,
    sbc_if.dev bus,
    input wire logic endian_select_pin,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [sbc_pkg::AD_W-1:0] req_addr,
    input wire logic req_block,
    input wire logic [1:0] req_size,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [sbc_pkg::DW_W-1:0] rd_data,
    output logic rd_last,
    output logic rd_err,
    output logic [4:0] release_cycles,
    output logic bus_released
);
    import sbc_pkg::*;

    typedef enum logic [2:0] {ST_OWN, ST_ADDR, ST_DATA, ST_SLAVE, ST_REGAIN} sbc_state_t;
    sbc_state_t state_ff, nxt_state;
    logic [AD_W-1:0] addr_ff, nxt_addr;
    logic [CMD_W-1:0] cmd_ff, nxt_cmd;
    logic split_ff, nxt_split;
    logic owner_n_ff, nxt_owner_n;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [4:0] rel_ff, nxt_rel;
    logic word_in, last_in, release_ok;
    logic f_in_ready, f_out_valid, f_out_ready;
    logic [FIFO_W-1:0] f_out;
    logic [CMD_W-1:0] cmd_in;

    assign cmd_in = bus.sys_command_bus;
    // Data cycle: the agent strobes valid with a data identifier on the bus.
    assign word_in = state_ff == ST_DATA && !bus.agent_data_valid_n && cmd_in[B_DATA];
    assign last_in = word_in && !cmd_in[B_LAST];
    // Requests wait for an empty buffer, so a whole block of eight always fits.
    // A pending split half has priority, so a new request must not be acknowledged meanwhile.
    assign req_ready = state_ff == ST_OWN && bus.ext_bus_request_n && !f_out_valid && f_in_ready && !split_ff;
    // Release only once the minimum latency has elapsed since the request.
    assign release_ok = !bus.ext_bus_request_n && cnt_ff >= 5'(REL_MIN_CYC - 1);

    always_comb begin
        nxt_state = state_ff;
        nxt_addr = addr_ff;
        nxt_cmd = cmd_ff;
        nxt_split = split_ff;
        nxt_owner_n = owner_n_ff;
        nxt_rel = rel_ff;
        // Counter runs while the request is held, saturating at its top.
        nxt_cnt = bus.ext_bus_request_n ? 5'h00 : (cnt_ff == 5'h1F ? cnt_ff : cnt_ff + 5'h01);
        unique case (state_ff)
            ST_OWN: begin
                if (release_ok) begin
                    nxt_state = ST_SLAVE;
                    nxt_owner_n = 1'b1;
                    nxt_rel = cnt_ff + 5'h01;
                end else if (split_ff && bus.ext_bus_request_n) begin
                    nxt_state = ST_ADDR;
                    nxt_split = 1'b0;
                end else if (req_valid && req_ready) begin
                    nxt_state = ST_ADDR;
                    nxt_addr = req_addr;
                    nxt_split = 1'b0;
                    nxt_cmd = rd_cmd(req_block, req_size);
                    if (req_block && req_size == BSZ_8 && (req_addr[4:0] & ALIGN8_MASK) != 5'h00) begin
                        nxt_cmd = rd_cmd(1'b1, BSZ_4);
                        nxt_split = 1'b1;
                    end else if (req_block && req_size == BSZ_RSV) begin
                        nxt_cmd = rd_cmd(1'b1, BSZ_2);
                    end
                end
            end
            ST_ADDR: begin
                nxt_state = ST_DATA;
            end
            ST_DATA: begin
                if (last_in) begin
                    nxt_state = ST_OWN;
                    // The second half of a split block fetches the other sub-block.
                    if (split_ff) begin
                        nxt_addr = addr_ff ^ SUB_TOGGLE;
                    end
                end
            end
            ST_SLAVE: begin
                if (bus.ext_bus_request_n) begin
                    nxt_state = ST_REGAIN;
                    nxt_cnt = 5'h00;
                end
            end
            ST_REGAIN: begin
                nxt_cnt = cnt_ff + 5'h01;
                if (!bus.ext_bus_request_n) begin
                    nxt_state = ST_SLAVE;
                end else if (cnt_ff == 5'(REGAIN_CYC - 1)) begin
                    nxt_state = ST_OWN;
                    nxt_owner_n = 1'b0;
                    nxt_cnt = 5'h00;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= ST_OWN;
            addr_ff <= '0;
            cmd_ff <= '0;
            split_ff <= 1'b0;
            owner_n_ff <= 1'b0;
            cnt_ff <= '0;
            rel_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            addr_ff <= nxt_addr;
            cmd_ff <= nxt_cmd;
            split_ff <= nxt_split;
            owner_n_ff <= nxt_owner_n;
            cnt_ff <= nxt_cnt;
            rel_ff <= nxt_rel;
        end
    end

    assign bus.proc_bus_owner_n = owner_n_ff;
    assign bus.dev_cmd = cmd_ff;
    assign bus.dev_ad = addr_ff;
    assign bus.dev_cmd_oe_n = state_ff != ST_ADDR;
    assign bus.dev_ad_oe_n = state_ff != ST_ADDR;
    assign bus.proc_addr_valid_n = state_ff != ST_ADDR;
    assign release_cycles = rel_ff;
    assign bus_released = owner_n_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Buffer entry: single flag, error bit, last flag, bus word.
    sbc_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(word_in),
        .in_ready(f_in_ready),
        .in_data({!cmd_ff[B_BLK], cmd_in[B_ERR], !cmd_in[B_LAST], bus.sys_addr_data_bus}),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    logic half_ff, nxt_half;
    logic [AD_W-1:0] hold_ff, nxt_hold;
    logic herr_ff, nxt_herr;
    logic v_ff, nxt_v, l_ff, nxt_l, e_ff, nxt_e;
    logic [DW_W-1:0] d_ff, nxt_d;

    assign f_out_ready = !v_ff || rd_ready;

    always_comb begin
        nxt_half = half_ff;
        nxt_hold = hold_ff;
        nxt_herr = herr_ff;
        nxt_v = v_ff && !rd_ready;
        nxt_d = d_ff;
        nxt_l = l_ff;
        nxt_e = e_ff;
        if (f_out_valid && f_out_ready) begin
            if (f_out[34]) begin
                nxt_v = 1'b1;
                nxt_d = {32'h0000_0000, f_out[31:0]};
                nxt_l = f_out[32];
                nxt_e = f_out[33];
            end else if (!half_ff) begin
                nxt_half = 1'b1;
                nxt_hold = f_out[31:0];
                nxt_herr = f_out[33];
            end else begin
                nxt_half = 1'b0;
                nxt_v = 1'b1;
                // Big-endian sends the high word first, little-endian the low word.
                nxt_d = endian_select_pin ? {hold_ff, f_out[31:0]} : {f_out[31:0], hold_ff};
                nxt_l = f_out[32];
                nxt_e = herr_ff || f_out[33];
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            half_ff <= 1'b0;
            hold_ff <= '0;
            herr_ff <= 1'b0;
            v_ff <= 1'b0;
            d_ff <= '0;
            l_ff <= 1'b0;
            e_ff <= 1'b0;
        end else begin
            half_ff <= nxt_half;
            hold_ff <= nxt_hold;
            herr_ff <= nxt_herr;
            v_ff <= nxt_v;
            d_ff <= nxt_d;
            l_ff <= nxt_l;
            e_ff <= nxt_e;
        end
    end

    assign rd_valid = v_ff;
    assign rd_data = d_ff;
    assign rd_last = l_ff;
    assign rd_err = e_ff;
endmodule : sbc_proc

// >>> hw/sbc_agent.sv
`timescale 1ns/1ns
module sbc_agent (
    input wire logic mclk,
    input wire logic sys_rst,
    sbc_if.agt bus,
    input wire logic endian_select_pin,
    input wire logic want_bus,
    output logic bus_granted,
    output logic cmd_valid,
    output logic [sbc_pkg::AD_W-1:0] cmd_addr,
    output logic cmd_block,
    output logic [1:0] cmd_size,
    output logic [1:0] rsp_dw_index,
    output logic rsp_word_hi,
    input wire logic rsp_valid,
    output logic rsp_ready,
    input wire logic [sbc_pkg::AD_W-1:0] rsp_data,
    input wire logic rsp_err
);
    import sbc_pkg::*;

    typedef enum logic {A_IDLE, A_SEND} sbc_agt_state_t;
    sbc_agt_state_t state_ff, nxt_state;
    logic [3:0] words_ff, nxt_words, idx_ff, nxt_idx;
    logic [1:0] start_ff, nxt_start;
    logic cv_ff, nxt_cv, blk_ff, nxt_blk, req_n_ff, nxt_req_n, dv_n_ff, nxt_dv_n;
    logic [1:0] sz_ff, nxt_sz;
    logic [AD_W-1:0] addr_ff, nxt_addr, ad_ff, nxt_ad;
    logic [CMD_W-1:0] id_ff, nxt_id, cmd_in;
    logic take;

    assign cmd_in = bus.sys_command_bus;
    // Only the processor's own command and write bit matter; reserved bits are not examined.
    assign take = state_ff == A_IDLE && !bus.proc_addr_valid_n && !cmd_in[B_DATA] && !cmd_in[B_RW];
    // Keep answering while asking for the bus, otherwise the processor could never finish and let go.
    assign rsp_ready = state_ff == A_SEND;

    always_comb begin
        nxt_state = state_ff;
        nxt_words = words_ff;
        nxt_idx = idx_ff;
        nxt_start = start_ff;
        nxt_cv = 1'b0;
        nxt_blk = blk_ff;
        nxt_sz = sz_ff;
        nxt_addr = addr_ff;
        nxt_ad = ad_ff;
        nxt_id = id_ff;
        nxt_dv_n = 1'b1;
        // Hold the request until the processor has actually let go.
        nxt_req_n = !(want_bus || (!req_n_ff && !bus.proc_bus_owner_n));
        if (take) begin
            nxt_state = A_SEND;
            nxt_cv = 1'b1;
            nxt_addr = bus.sys_addr_data_bus;
            nxt_blk = cmd_in[B_BLK];
            nxt_sz = cmd_in[1:0];
            nxt_words = words_of(cmd_in);
            nxt_start = bus.sys_addr_data_bus[DW_LSB+1:DW_LSB];
            nxt_idx = 4'h0;
        end else if (rsp_valid && rsp_ready) begin
            nxt_dv_n = 1'b0;
            nxt_ad = rsp_data;
            nxt_id = agt_data_id(idx_ff == words_ff - 4'h1, rsp_err);
            nxt_idx = idx_ff + 4'h1;
            if (idx_ff == words_ff - 4'h1) begin
                nxt_state = A_IDLE;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= A_IDLE;
            words_ff <= 4'h1;
            idx_ff <= '0;
            start_ff <= '0;
            cv_ff <= 1'b0;
            blk_ff <= 1'b0;
            sz_ff <= '0;
            addr_ff <= '0;
            ad_ff <= '0;
            id_ff <= 5'h1F;
            req_n_ff <= 1'b1;
            dv_n_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            words_ff <= nxt_words;
            idx_ff <= nxt_idx;
            start_ff <= nxt_start;
            cv_ff <= nxt_cv;
            blk_ff <= nxt_blk;
            sz_ff <= nxt_sz;
            addr_ff <= nxt_addr;
            ad_ff <= nxt_ad;
            id_ff <= nxt_id;
            req_n_ff <= nxt_req_n;
            dv_n_ff <= nxt_dv_n;
        end
    end

    // Doubleword k of the block is the start index XOR k.
    assign rsp_dw_index = start_ff ^ idx_ff[2:1];
    // Little-endian sends the low word of each pair first.
    assign rsp_word_hi = blk_ff && (idx_ff[0] ^ endian_select_pin);
    assign bus_granted = !req_n_ff && bus.proc_bus_owner_n;
    assign cmd_valid = cv_ff;
    assign cmd_addr = addr_ff;
    assign cmd_block = blk_ff;
    assign cmd_size = sz_ff;
    assign bus.ext_bus_request_n = req_n_ff;
    assign bus.agent_data_valid_n = dv_n_ff;
    assign bus.agt_cmd = id_ff;
    assign bus.agt_ad = ad_ff;
    assign bus.agt_cmd_oe_n = dv_n_ff;
    assign bus.agt_ad_oe_n = dv_n_ff;
endmodule : sbc_agent

// >>> tb/sbc_sva.sv
`timescale 1ns/1ns
module sbc_sva (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic dev_cmd_oe_n,
    input wire logic dev_ad_oe_n,
    input wire logic agt_cmd_oe_n,
    input wire logic proc_addr_valid_n,
    input wire logic proc_bus_owner_n,
    input wire logic agent_data_valid_n,
    input wire logic ext_bus_request_n,
    input wire logic [4:0] sys_command_bus
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    chk_read_cmd_code: assert property (!proc_addr_valid_n |-> sys_command_bus[4:3] == 2'b00 && !dev_cmd_oe_n)
        else $error("bad command code in address cycle");
    chk_addr_one_cycle: assert property (!proc_addr_valid_n |=> proc_addr_valid_n)
        else $error("address cycle longer than one cycle");
    chk_data_id_code: assert property (!agent_data_valid_n |-> sys_command_bus[4] && !sys_command_bus[2]
        && sys_command_bus[0] && dev_cmd_oe_n)
        else $error("bad data identifier from agent");
    chk_release_floor: assert property ($fell(ext_bus_request_n) && !proc_bus_owner_n |-> !proc_bus_owner_n [*4])
        else $error("bus released too early");
    chk_release_ceiling: assert property ($fell(ext_bus_request_n) && !proc_bus_owner_n |-> ##[1:25] proc_bus_owner_n)
        else $error("bus not released in time");
    // Once handed over, the bus stays with the agent while it still asks for it.
    chk_release_hold: assert property (proc_bus_owner_n && !ext_bus_request_n |=> proc_bus_owner_n)
        else $error("bus taken back under request");
    chk_slave_quiet: assert property (proc_bus_owner_n |-> dev_cmd_oe_n && dev_ad_oe_n && proc_addr_valid_n)
        else $error("processor drives while released");
    chk_one_driver: assert property (!agt_cmd_oe_n |-> dev_cmd_oe_n)
        else $error("both ends drive the command bus");
    chk_request_held: assert property (!ext_bus_request_n && !proc_bus_owner_n |=> !ext_bus_request_n)
        else $error("agent dropped request before release");
    chk_regain_bound: assert property ($rose(ext_bus_request_n) && proc_bus_owner_n |=> ##[0:3] !proc_bus_owner_n)
        else $error("processor did not regain the bus");
endmodule : sbc_sva

// >>> tb/sbc_tb_top.sv
`timescale 1ns/1ns
module sysbus_command_codec_tb_top;
    import sbc_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic endian_select_pin = 1'b0;
    logic req_valid = 1'b0;
    logic [31:0] req_addr = 32'h0;
    logic req_block = 1'b0;
    logic [1:0] req_size = 2'h0;
    logic want_bus = 1'b0;
    logic rsp_err = 1'b0;
    logic [1:0] dw_msk = 2'h0;
    logic rd_ready = 1'b1;
    logic req_ready, rd_valid, rd_last, rd_err, bus_released, bus_granted, cmd_valid, cmd_block, rsp_ready;
    logic rsp_word_hi;
    logic [63:0] rd_data;
    logic [4:0] release_cycles;
    logic [31:0] cmd_addr, rsp_data;
    logic [1:0] cmd_size, rsp_dw_index;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;

    sbc_if u_sbc_if ();
    sbc_proc u_sbc_proc (.mclk, .sys_rst, .bus(u_sbc_if.dev), .endian_select_pin, .req_valid, .req_ready, .req_addr,
        .req_block, .req_size, .rd_valid, .rd_ready, .rd_data, .rd_last, .rd_err, .release_cycles, .bus_released);
    sbc_agent u_sbc_agent (.mclk, .sys_rst, .bus(u_sbc_if.agt), .endian_select_pin, .want_bus, .bus_granted,
        .cmd_valid, .cmd_addr, .cmd_block, .cmd_size, .rsp_dw_index, .rsp_word_hi, .rsp_valid(1'b1), .rsp_ready,
        .rsp_data, .rsp_err);
    sbc_sva u_sbc_sva (.mclk, .sys_rst, .dev_cmd_oe_n(u_sbc_if.dev_cmd_oe_n), .dev_ad_oe_n(u_sbc_if.dev_ad_oe_n),
        .agt_cmd_oe_n(u_sbc_if.agt_cmd_oe_n), .proc_addr_valid_n(u_sbc_if.proc_addr_valid_n),
        .proc_bus_owner_n(u_sbc_if.proc_bus_owner_n), .agent_data_valid_n(u_sbc_if.agent_data_valid_n),
        .ext_bus_request_n(u_sbc_if.ext_bus_request_n), .sys_command_bus(u_sbc_if.sys_command_bus));

    // Each bus word names its doubleword and half, so order faults show in the data.
    function automatic logic [31:0] wd(input logic [1:0] i, input logic h);
        wd = {16'hA5A5, 10'h000, i, 3'h0, h};
    endfunction : wd
    assign rsp_data = wd(rsp_dw_index & dw_msk, rsp_word_hi);

    always #5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            $display("mismatch timeout expected done seen hang");
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic run_read(input logic [31:0] a, input logic blk, input logic [1:0] sz, input logic be,
        input logic er);
        int np;
        int lp;
        int wpx;
        int k;
        int w;
        int h;
        logic [1:0] esz;
        logic [1:0] dwi;
        esz = !blk ? sz : (sz == BSZ_8 && a[4:0] != 5'h00) ? BSZ_4 : (sz == BSZ_RSV) ? BSZ_2 : sz;
        np = !blk ? 1 : (sz == BSZ_4) ? 2 : (sz == BSZ_8) ? 4 : 1;
        lp = !blk ? 1 : (esz == BSZ_2) ? 1 : (esz == BSZ_4) ? 2 : 4;
        wpx = blk ? 2 * lp : 1;
        k = 0;
        w = 0;
        h = 0;
        @(posedge mclk);
        endian_select_pin <= be;
        req_addr <= a;
        req_block <= blk;
        req_size <= sz;
        rsp_err <= er;
        dw_msk <= 2'(lp - 1);
        req_valid <= 1'b1;
        for (int c = 0; c < 300 && k < np; c++) begin
            @(posedge mclk);
            if (req_valid && req_ready) req_valid <= 1'b0;
            if (!u_sbc_if.proc_addr_valid_n) begin
                chk("cmd code", {2'b00, blk, esz}, u_sbc_if.sys_command_bus);
                chk("cmd addr", h ? a ^ SUB_TOGGLE : a, u_sbc_if.sys_addr_data_bus);
                h++;
            end
            if (cmd_valid) chk("agent cmd", {blk, esz, (h > 1 ? a ^ SUB_TOGGLE : a)}, {cmd_block, cmd_size, cmd_addr});
            if (!u_sbc_if.agent_data_valid_n) begin
                chk("last bit", (w % wpx) != (wpx - 1), u_sbc_if.sys_command_bus[3]);
                if (blk) chk("word half", be ^ w[0], u_sbc_if.sys_addr_data_bus[0]);
                w++;
            end
            if (rd_valid) begin
                dwi = (a[4:3] ^ 2'(k)) & 2'(lp - 1);
                chk("rd data", blk ? {wd(dwi, 1'b1), wd(dwi, 1'b0)} : {32'h0, wd(2'h0, 1'b0)}, rd_data);
                chk("rd last", (k + 1) % lp == 0, rd_last);
                chk("rd err", er, rd_err);
                k++;
            end
        end
        chk("pairs", np, k);
        $display("read %h done", a);
    endtask : run_read

    task automatic run_release(input logic mid);
        int n;
        int k;
        n = 0;
        k = 0;
        @(posedge mclk);
        endian_select_pin <= 1'b0;
        req_addr <= 32'h0000_0200;
        req_block <= 1'b1;
        req_size <= BSZ_4;
        dw_msk <= 2'h1;
        // In the mid case the request rises one cycle before the final data cycle of a read.
        req_valid <= mid;
        want_bus <= !mid;
        for (int c = 0; c < 40; c++) begin
            @(posedge mclk);
            if (bus_released) break;
            if (req_valid && req_ready) req_valid <= 1'b0;
            if (!u_sbc_if.agent_data_valid_n) want_bus <= 1'b1;
            if (rd_valid) k++;
            if (!u_sbc_if.ext_bus_request_n) n++;
        end
        @(posedge mclk);
        chk("latency range", 1, n >= REL_MIN_CYC && n <= (mid ? REL_CAT1_MAX : REL_CAT2_MAX));
        chk("latency count", n, release_cycles);
        chk("read pairs", mid ? 2 : 0, k);
        chk("granted", 2'b10, {bus_granted, req_ready});
        want_bus <= 1'b0;
        for (int c = 0; c < 10 && bus_released; c++) @(posedge mclk);
        chk("regained", 0, {bus_released, bus_granted});
        $display("release done");
    endtask : run_release

    // The reader holds off a whole aligned block, so the buffer inside the processor must keep it.
    task automatic run_fifo();
        int m;
        m = 0;
        @(posedge mclk);
        rd_ready <= 1'b0;
        endian_select_pin <= 1'b0;
        req_addr <= 32'h0000_0200;
        req_block <= 1'b1;
        req_size <= BSZ_8;
        dw_msk <= 2'h3;
        req_valid <= 1'b1;
        repeat (20) begin
            @(posedge mclk);
            if (req_valid && req_ready) req_valid <= 1'b0;
        end
        chk("fifo hold", 2'b10, {rd_valid, req_ready});
        // Ready toggles so the reader stalls every other cycle.
        for (int c = 0; c < 30; c++) begin
            @(posedge mclk);
            if (rd_valid && rd_ready) begin
                chk("fifo data", {wd(2'(m), 1'b1), wd(2'(m), 1'b0)}, rd_data);
                m++;
            end
            rd_ready <= ~rd_ready;
        end
        chk("fifo drain", {32'h4, 1'b0}, {32'(m), rd_valid});
        @(posedge mclk);
        rd_ready <= 1'b1;
        $display("fifo done");
    endtask : run_fifo

    initial begin
        repeat (2) @(posedge mclk);
        chk("reset outs", {3'b000, 5'h00}, {u_sbc_if.proc_bus_owner_n, rd_valid, cmd_valid, release_cycles});
        sys_rst <= 1'b0;
        for (int s = 0; s < 8; s++) run_read(32'h0000_0100, 1'b0, 2'(s), s[2], 1'b0);
        run_read(32'h0000_0208, 1'b1, BSZ_2, 1'b0, 1'b0);
        run_read(32'h0000_0218, 1'b1, BSZ_4, 1'b1, 1'b0);
        run_read(32'h0000_0200, 1'b1, BSZ_8, 1'b0, 1'b0);
        run_read(32'h0000_0208, 1'b1, BSZ_8, 1'b1, 1'b0);
        run_read(32'h0000_0300, 1'b1, BSZ_RSV, 1'b0, 1'b1);
        run_read(32'h0000_0104, 1'b0, RSZ_WORD, 1'b1, 1'b1);
        run_release(1'b0);
        run_read(32'h0000_0218, 1'b1, BSZ_8, 1'b0, 1'b0);
        run_release(1'b1);
        run_fifo();
        stop_test();
    end
endmodule : sysbus_command_codec_tb_top
